// ==== design/lprc_pkg.sv ====
// Constants shared by the loopback, power-down and reset control block
package lprc_pkg;
   // ***********************************************
   // Sizes
   // ***********************************************
   localparam int NCH    = 8;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // ***********************************************
   // Register indices (byte address is the index itself)
   // ***********************************************
   localparam logic [ADDR_W-1:0] REG_GLOBAL_CONFIG = 4'h0;
   localparam logic [ADDR_W-1:0] REG_SOFT_RESET    = 4'h1;
   localparam logic [ADDR_W-1:0] REG_TX_POWERDOWN  = 4'h2;
   localparam logic [ADDR_W-1:0] REG_RX_POWERDOWN  = 4'h3;
   localparam logic [ADDR_W-1:0] REG_DIGITAL_LOOP  = 4'h4;
   localparam logic [ADDR_W-1:0] REG_ANALOG_LOOP   = 4'h5;
   localparam logic [ADDR_W-1:0] REG_REMOTE_LOOP   = 4'h6;
   localparam logic [ADDR_W-1:0] REG_ALL_ONES      = 4'h7;
   localparam logic [ADDR_W-1:0] REG_AUTO_ALL_ONES = 4'h8;
   localparam logic [ADDR_W-1:0] REG_TX_HIGHZ      = 4'h9;
   localparam logic [ADDR_W-1:0] REG_TX_PD_STATUS  = 4'hA;
   localparam logic [ADDR_W-1:0] REG_RX_PD_STATUS  = 4'hB;
   localparam logic [ADDR_W-1:0] REG_ONES_STATUS   = 4'hC;
   localparam logic [ADDR_W-1:0] REG_LOSS_STATUS   = 4'hD;
   localparam logic [ADDR_W-1:0] REG_MODE_STATUS   = 4'hE;

   // Field positions and reset values
   localparam int                AIS_ENABLE_BIT = 0;
   localparam logic [DATA_W-1:0] RESET_VALUE    = 8'h00;

   // ***********************************************
   // Timing
   // ***********************************************
   localparam int CLK_MHZ          = 40;
   localparam int SOFT_RESET_NS    = 1000;
   localparam int SOFT_RESET_CYC   = (SOFT_RESET_NS * CLK_MHZ + 999) / 1000;
   localparam int POWER_ON_US      = 10;
   localparam int POWER_ON_CYC     = POWER_ON_US * CLK_MHZ;
   localparam int NO_MCLK_LOW_US   = 30;
   localparam int NO_MCLK_LOW_CYC  = NO_MCLK_LOW_US * CLK_MHZ;
   localparam int TX_LOW_MCLK_CYC  = 64;
   localparam int TX_HIGH_MCLK_CYC = 16;
   localparam int MCLK_STALL_CYC   = 8;
   localparam int LOOP_LOS_ZEROS   = 32;
endpackage : lprc_pkg

// ==== design/lprc_top.sv ====
// Loopback, power-down, all-ones and reset control for eight line channels
// Behaviour
// (RQ1) Soft reset write resets registers about 1 us
// (RQ2) Power-on reset holds defaults at least 10 us
// (RQ3) Transmit clock low long powers transmitter down
// (RQ4) Host mode: transmit power-down bit powers down
// (RQ5) Master clock low powers down all receivers
// (RQ6) Receiver power-down bit powers that receiver down
// (RQ7) Hardware mode: pin picks analog or remote
// (RQ8) Digital loop: transmit data to receive outputs
// (RQ9) Loss in digital loop: alarm and auto ones
// (RQ10) Alarm enable global; auto ones defaults off
// (RQ11) Analog loop: driver output feeds receive path
// (RQ12) Software avoids auto ones in analog loop
// (RQ13) Remote loop: recovered data drives line
// (RQ14) Digital plus remote bits give dual loop
// (RQ15) Transmit clock high long gives all ones; code does this in hardware mode only
// (RQ16) Host all-ones bit, auto on loss, master-timed
// (RQ17) Line driver has a high-impedance state
// (RQ18) Violations suppressed in all-ones with line loops
// (RQ19) Bit n drives channel n independently
//
// The plain strobed port and the register addresses were chosen for this implementation.
module lprc_top (
   input  wire logic                        clk,
   input  wire logic                        reset,
   input  wire logic                        mclk,
   input  wire logic                        mclk_level,
   input  wire logic                        host_mode,
   input  wire logic [lprc_pkg::ADDR_W-1:0] addr,
   input  wire logic [lprc_pkg::DATA_W-1:0] wr_data,
   input  wire logic                        wr_en,
   input  wire logic                        rd_en,
   output logic      [lprc_pkg::DATA_W-1:0] rd_data,
   input  wire logic [lprc_pkg::NCH-1:0]    tx_clock_in,
   input  wire logic [lprc_pkg::NCH-1:0]    loop_select_pin,
   input  wire logic [lprc_pkg::NCH-1:0]    tx_data_pos_in,
   input  wire logic [lprc_pkg::NCH-1:0]    tx_violation_neg_in,
   input  wire logic [lprc_pkg::NCH-1:0]    rx_line_pos,
   input  wire logic [lprc_pkg::NCH-1:0]    rx_line_neg,
   input  wire logic [lprc_pkg::NCH-1:0]    los_in,
   output logic      [lprc_pkg::NCH-1:0]    tx_line_pos,
   output logic      [lprc_pkg::NCH-1:0]    tx_line_neg,
   output logic      [lprc_pkg::NCH-1:0]    tx_line_oe,
   output logic      [lprc_pkg::NCH-1:0]    rx_data_pos_out,
   output logic      [lprc_pkg::NCH-1:0]    rx_violation_neg_out,
   output logic      [lprc_pkg::NCH-1:0]    tx_powered_down,
   output logic      [lprc_pkg::NCH-1:0]    rx_powered_down,
   output logic                             internal_reset
);
   localparam int N = lprc_pkg::NCH;
   localparam int W = lprc_pkg::DATA_W;
   localparam int SOFT_N = lprc_pkg::SOFT_RESET_CYC;
   localparam logic [8:0] POR_LAST  = 9'(lprc_pkg::POWER_ON_CYC - 1);
   localparam logic [5:0] SOFT_LAST = 6'(lprc_pkg::SOFT_RESET_CYC - 1);
   localparam logic [3:0] STALL_MAX = 4'(lprc_pkg::MCLK_STALL_CYC);
   localparam logic [5:0] LOS_ZEROS = 6'(lprc_pkg::LOOP_LOS_ZEROS);

   typedef enum logic [2:0] {
      RST_POWER_ON = 3'b001,
      RST_SOFT     = 3'b010,
      RST_RUN      = 3'b100
   } lprc_rst_e;

   lprc_rst_e   rst_state;
   lprc_rst_e   next_rst_state;
   logic [8:0]  rst_cnt;
   logic        int_rst;

   logic [W-1:0] global_config_reg;
   logic [N-1:0] tx_powerdown_reg;
   logic [N-1:0] rx_powerdown_reg;
   logic [N-1:0] digital_loop_reg;
   logic [N-1:0] analog_loop_reg;
   logic [N-1:0] remote_loop_reg;
   logic [N-1:0] all_ones_reg;
   logic [N-1:0] auto_all_ones_reg;
   logic [N-1:0] tx_highz_reg;

   logic [2*N+1:0] pin_s1, pin_s2, pin_s3, pin_ok;
   logic [N-1:0]   txc_lvl, loop_pin_lvl;
   logic           host_lvl, mclk_lvl;
   logic           mclk_tog, m_rst, m_rst1;
   logic [2:0]     mclk_tog_s;
   logic           mclk_tick;
   logic [3:0]     stall_cnt;
   logic           mclk_present;
   logic [N-1:0]   pd_req, hw_ones;
   logic [N-1:0]   dl_eff, al_eff, rl_eff, ones_eff;
   logic [N-1:0]   tx_pd_q, rx_pd_q;
   logic [N-1:0]   loss_s1, loss_s2;

   // ***********************************************
   // Internal reset sequencing
   // ***********************************************
   wire soft_wr = wr_en && addr == lprc_pkg::REG_SOFT_RESET;

   always_comb begin
      next_rst_state = rst_state;
      unique case (rst_state)
         RST_POWER_ON: if (rst_cnt == POR_LAST) next_rst_state = RST_RUN;
         RST_SOFT:     if (rst_cnt[5:0] == SOFT_LAST) next_rst_state = RST_RUN;
         RST_RUN:      if (soft_wr) next_rst_state = RST_SOFT;
         default:      next_rst_state = RST_POWER_ON;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rst_state <= RST_POWER_ON; // [RQ2]
         rst_cnt   <= 9'h000;
      end else begin
         rst_state <= next_rst_state; // [RQ1]
         rst_cnt   <= (next_rst_state != rst_state) ? 9'h000 : rst_cnt + 9'h001;
      end
   end

   assign int_rst = rst_state != RST_RUN;

   always_ff @(posedge clk) begin
      if (reset)
         internal_reset <= 1'b1;
      else
         internal_reset <= next_rst_state != RST_RUN;
   end

   // ***********************************************
   // Pin sampling: a change counts when stages two and three agree
   // ***********************************************
   always_ff @(posedge clk) begin
      pin_s1 <= {mclk_level, host_mode, loop_select_pin, tx_clock_in};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
   end

   generate
      for (genvar b = 0; b < 2*N+2; b++) begin : g_pin
         always_ff @(posedge clk) begin
            if (reset)
               pin_ok[b] <= 1'b0;
            else if (pin_s2[b] == pin_s3[b])
               pin_ok[b] <= pin_s3[b];
         end
      end
   endgenerate

   assign txc_lvl      = pin_ok[N-1:0];
   assign loop_pin_lvl = pin_ok[2*N-1:N];
   assign host_lvl     = pin_ok[2*N];
   assign mclk_lvl     = pin_ok[2*N+1];

   // ***********************************************
   // Master clock activity, crossed as a toggle
   // ***********************************************
   // Held in reset so the toggle never starts unknown
   always_ff @(posedge mclk) begin
      if (m_rst)
         mclk_tog <= 1'b0;
      else
         mclk_tog <= !mclk_tog;
   end

   always_ff @(posedge clk) begin
      mclk_tog_s <= {mclk_tog_s[1:0], mclk_tog};
   end

   assign mclk_tick = mclk_tog_s[2] != mclk_tog_s[1];

   always_ff @(posedge clk) begin
      if (reset)
         stall_cnt <= STALL_MAX;
      else if (mclk_tick)
         stall_cnt <= 4'h0;
      else if (stall_cnt != STALL_MAX)
         stall_cnt <= stall_cnt + 4'h1;
   end

   assign mclk_present = stall_cnt != STALL_MAX;

   generate
      for (genvar c = 0; c < N; c++) begin : g_mon
         lprc_tx_clk_mon u_mon (
            .clk          (clk),
            .reset        (int_rst),
            .tx_clk_level (txc_lvl[c]),
            .mclk_tick    (mclk_tick),
            .mclk_present (mclk_present),
            .pd_req       (pd_req[c]),
            .ones_req     (hw_ones[c])
         );
      end
   endgenerate

   // ***********************************************
   // Register writes
   // ***********************************************
   always_ff @(posedge clk) begin
      if (int_rst) begin
         global_config_reg <= lprc_pkg::RESET_VALUE; // [RQ1] [RQ2]
         tx_powerdown_reg  <= lprc_pkg::RESET_VALUE;
         rx_powerdown_reg  <= lprc_pkg::RESET_VALUE;
         digital_loop_reg  <= lprc_pkg::RESET_VALUE;
         analog_loop_reg   <= lprc_pkg::RESET_VALUE;
         remote_loop_reg   <= lprc_pkg::RESET_VALUE;
         all_ones_reg      <= lprc_pkg::RESET_VALUE;
         auto_all_ones_reg <= lprc_pkg::RESET_VALUE; // [RQ10]
         tx_highz_reg      <= lprc_pkg::RESET_VALUE;
      end else if (wr_en) begin
         unique case (addr)
            lprc_pkg::REG_GLOBAL_CONFIG: global_config_reg <= wr_data; // [RQ10]
            lprc_pkg::REG_TX_POWERDOWN:  tx_powerdown_reg  <= wr_data;
            lprc_pkg::REG_RX_POWERDOWN:  rx_powerdown_reg  <= wr_data;
            lprc_pkg::REG_DIGITAL_LOOP:  digital_loop_reg  <= wr_data;
            lprc_pkg::REG_ANALOG_LOOP:   analog_loop_reg   <= wr_data;
            lprc_pkg::REG_REMOTE_LOOP:   remote_loop_reg   <= wr_data;
            lprc_pkg::REG_ALL_ONES:      all_ones_reg      <= wr_data;
            lprc_pkg::REG_AUTO_ALL_ONES: auto_all_ones_reg <= wr_data;
            lprc_pkg::REG_TX_HIGHZ:      tx_highz_reg      <= wr_data;
            default: ;
         endcase
      end
   end

   // ***********************************************
   // Per-channel mode selection, bit n for channel n
   // ***********************************************
   always_ff @(posedge clk) begin
      if (int_rst) begin
         dl_eff   <= '0;
         al_eff   <= '0;
         rl_eff   <= '0;
         ones_eff <= '0;
         tx_pd_q  <= '0;
         rx_pd_q  <= '0;
      end else begin
         // Digital and dual loop are reachable from registers only
         dl_eff   <= host_lvl ? digital_loop_reg : '0; // [RQ7] [RQ8] [RQ14] [RQ19]
         al_eff   <= host_lvl ? analog_loop_reg : loop_pin_lvl; // [RQ7] [RQ11]
         rl_eff   <= host_lvl ? remote_loop_reg : ~loop_pin_lvl; // [RQ7] [RQ13]
         ones_eff <= host_lvl ? all_ones_reg : hw_ones; // [RQ15] [RQ16]
         tx_pd_q  <= pd_req | (host_lvl ? tx_powerdown_reg : '0); // [RQ3] [RQ4]
         // Master clock stopped low wins over every receiver setting
         rx_pd_q  <= (!mclk_present && !mclk_lvl) ? '1 : rx_powerdown_reg; // [RQ5] [RQ6]
      end
   end

   always_ff @(posedge clk) begin
      if (int_rst) begin
         tx_powered_down <= '0;
         rx_powered_down <= '0;
      end else begin
         tx_powered_down <= tx_pd_q;
         rx_powered_down <= rx_pd_q;
      end
   end

   // ***********************************************
   // Register reads: data only in the cycle after the strobe
   // ***********************************************
   always_ff @(posedge clk) begin
      if (reset || !rd_en) begin
         rd_data <= '0;
      end else begin
         unique case (addr)
            lprc_pkg::REG_GLOBAL_CONFIG: rd_data <= global_config_reg;
            lprc_pkg::REG_TX_POWERDOWN:  rd_data <= tx_powerdown_reg;
            lprc_pkg::REG_RX_POWERDOWN:  rd_data <= rx_powerdown_reg;
            lprc_pkg::REG_DIGITAL_LOOP:  rd_data <= digital_loop_reg;
            lprc_pkg::REG_ANALOG_LOOP:   rd_data <= analog_loop_reg;
            lprc_pkg::REG_REMOTE_LOOP:   rd_data <= remote_loop_reg;
            lprc_pkg::REG_ALL_ONES:      rd_data <= all_ones_reg;
            lprc_pkg::REG_AUTO_ALL_ONES: rd_data <= auto_all_ones_reg;
            lprc_pkg::REG_TX_HIGHZ:      rd_data <= tx_highz_reg;
            lprc_pkg::REG_TX_PD_STATUS:  rd_data <= tx_pd_q;
            lprc_pkg::REG_RX_PD_STATUS:  rd_data <= rx_pd_q;
            lprc_pkg::REG_ONES_STATUS:   rd_data <= ones_eff;
            lprc_pkg::REG_LOSS_STATUS:   rd_data <= loss_s2;
            lprc_pkg::REG_MODE_STATUS:   rd_data <= {6'h00, mclk_present, host_lvl};
            default:                     rd_data <= '0;
         endcase
      end
   end

   // ***********************************************
   // Line side, on the master clock
   // ***********************************************
   logic [N-1:0] m_dl, m_al, m_rl, m_ones, m_aao, m_hz, m_txpd, m_rxpd;
   logic [N-1:0] m_dl1, m_al1, m_rl1, m_ones1, m_aao1, m_hz1, m_txpd1, m_rxpd1;
   logic         m_ais, m_ais1;
   logic         ones_phase;
   logic [N-1:0] loss;

   // Independent level bits, each crossing on its own
   always_ff @(posedge mclk) begin
      {m_dl1, m_al1, m_rl1, m_ones1} <= {dl_eff, al_eff, rl_eff, ones_eff};
      {m_aao1, m_hz1, m_txpd1, m_rxpd1} <= {auto_all_ones_reg, tx_highz_reg, tx_pd_q, rx_pd_q};
      {m_ais1, m_rst1} <= {global_config_reg[lprc_pkg::AIS_ENABLE_BIT], int_rst};
      {m_dl, m_al, m_rl, m_ones} <= {m_dl1, m_al1, m_rl1, m_ones1};
      {m_aao, m_hz, m_txpd, m_rxpd} <= {m_aao1, m_hz1, m_txpd1, m_rxpd1};
      {m_ais, m_rst} <= {m_ais1, m_rst1};
   end

   // All-ones marks alternate polarity, timed from the master clock
   always_ff @(posedge mclk) begin
      if (m_rst)
         ones_phase <= 1'b0;
      else
         ones_phase <= !ones_phase; // [RQ16]
   end

   generate
      for (genvar c = 0; c < N; c++) begin : g_line
         logic [5:0] zero_run;
         logic       loop_p, loop_n, src_p, src_n, send_ones;

         always_comb begin
            // Analog loop watches the looped driver output, else the line
            loss[c]   = m_al[c] ? (zero_run == LOS_ZEROS) : los_in[c]; // [RQ9] [RQ11]
            send_ones = m_ones[c] || (m_aao[c] && loss[c]); // [RQ9] [RQ16]
            loop_p    = m_rl[c] ? rx_line_pos[c] : tx_data_pos_in[c]; // [RQ13]
            loop_n    = m_rl[c] ? rx_line_neg[c] : tx_violation_neg_in[c];
            // Dual loop sends encoded data inward, line data outward
            src_p     = m_dl[c] ? tx_data_pos_in[c] : m_al[c] ? tx_line_pos[c] : rx_line_pos[c]; // [RQ8] [RQ14]
            src_n     = m_dl[c] ? tx_violation_neg_in[c] : m_al[c] ? tx_line_neg[c] : rx_line_neg[c];
         end

         always_ff @(posedge mclk) begin
            if (m_rst || tx_line_pos[c] || tx_line_neg[c])
               zero_run <= 6'h00;
            else if (zero_run != LOS_ZEROS)
               zero_run <= zero_run + 6'h01;
         end

         // Generated ones carry no violation on any loop
         always_ff @(posedge mclk) begin
            if (m_rst || m_txpd[c]) begin
               tx_line_pos[c] <= 1'b0;
               tx_line_neg[c] <= 1'b0;
            end else if (send_ones) begin
               tx_line_pos[c] <= ones_phase; // [RQ18]
               tx_line_neg[c] <= !ones_phase;
            end else begin
               tx_line_pos[c] <= loop_p; // [RQ8] [RQ13]
               tx_line_neg[c] <= loop_n;
            end
         end

         always_ff @(posedge mclk) begin
            if (m_rst)
               tx_line_oe[c] <= 1'b0;
            else
               tx_line_oe[c] <= !m_txpd[c] && !m_hz[c]; // [RQ17]
         end

         always_ff @(posedge mclk) begin
            if (m_rst || m_rxpd[c]) begin
               rx_data_pos_out[c]      <= 1'b0;
               rx_violation_neg_out[c] <= 1'b0;
            end else if (m_ais && loss[c]) begin
               rx_data_pos_out[c]      <= ones_phase; // [RQ9]
               rx_violation_neg_out[c] <= !ones_phase;
            end else begin
               rx_data_pos_out[c]      <= src_p; // [RQ11]
               rx_violation_neg_out[c] <= src_n;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      loss_s1 <= loss;
      loss_s2 <= loss_s1;
   end

   // ***********************************************
   // Checks
   // ***********************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_soft_busy;
      int_rst [*8];
   endsequence

   chk_soft_reset_len : assert property (soft_wr && !int_rst |=> s_soft_busy ##(SOFT_N - 7) !int_rst) // [RQ1]
      else $error("soft reset cycle length wrong");
   chk_por_defaults : assert property (rst_state == RST_POWER_ON |-> int_rst ##1 auto_all_ones_reg == '0) // [RQ2]
      else $error("power-on reset did not hold defaults");
   chk_tx_pd_bit : assert property (!int_rst && host_lvl && tx_powerdown_reg[0] |=> tx_pd_q[0]) // [RQ4]
      else $error("transmit power-down bit ignored");
   chk_mclk_low_rx : assert property (!int_rst && !mclk_present && !mclk_lvl |=> rx_pd_q == '1) // [RQ5]
      else $error("receivers not down with master clock low");
   chk_rx_pd_bit : assert property (!int_rst && !soft_wr && rx_powerdown_reg[1] |=> rx_pd_q[1] ##1 rx_powered_down[1]) // [RQ6]
      else $error("receiver power-down bit ignored");
   chk_hw_loop_pin : assert property (!int_rst && !host_lvl |=> dl_eff == '0 && rl_eff == ~$past(loop_pin_lvl)) // [RQ7]
      else $error("hardware loop selection wrong");
   chk_auto_default : assert property (int_rst |=> auto_all_ones_reg == '0 || !$past(int_rst, 1)) // [RQ10]
      else $error("auto all-ones not disabled by reset");
   chk_highz_oe : assert property (@(posedge mclk) disable iff (m_rst) m_hz[2] |=> !tx_line_oe[2]) // [RQ17]
      else $error("line driver not released in high impedance");
   chk_dl_receive : assert property (@(posedge mclk) disable iff (m_rst)
      m_dl[3] && !m_rxpd[3] && !(m_ais && loss[3]) |=> rx_data_pos_out[3] == $past(tx_data_pos_in[3])) // [RQ8]
      else $error("digital loop did not return transmit data");
endmodule : lprc_top

// ==== design/lprc_tx_clk_mon.sv ====
// Per-channel transmit clock watcher: power-down and all-ones requests
module lprc_tx_clk_mon (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic tx_clk_level,
   input  wire logic mclk_tick,
   input  wire logic mclk_present,
   output logic      pd_req,
   output logic      ones_req
);
   localparam logic [10:0] LOW_MCLK  = 11'(lprc_pkg::TX_LOW_MCLK_CYC);
   localparam logic [10:0] LOW_NOCLK = 11'(lprc_pkg::NO_MCLK_LOW_CYC);
   localparam logic [10:0] HIGH_MCLK = 11'(lprc_pkg::TX_HIGH_MCLK_CYC);

   logic [10:0] low_ticks;
   logic [10:0] low_cycles;
   logic [10:0] high_ticks;

   // ***********************************************
   // Low time, measured in master clocks or in local time
   // ***********************************************
   always_ff @(posedge clk) begin
      if (reset || tx_clk_level) begin
         low_ticks  <= 11'h000;
         low_cycles <= 11'h000;
      end else begin
         if (mclk_tick && low_ticks <= LOW_MCLK)
            low_ticks <= low_ticks + 11'h001;
         if (!mclk_present && low_cycles < LOW_NOCLK)
            low_cycles <= low_cycles + 11'h001;
      end
   end

   // Saturating so a long stop never wraps back to running
   always_ff @(posedge clk) begin
      if (reset || !tx_clk_level)
         high_ticks <= 11'h000;
      else if (mclk_tick && high_ticks <= HIGH_MCLK)
         high_ticks <= high_ticks + 11'h001;
   end

   always_ff @(posedge clk) begin
      if (reset)
         pd_req <= 1'b0;
      else
         pd_req <= !tx_clk_level && (low_ticks > LOW_MCLK || low_cycles >= LOW_NOCLK); // [RQ3]
   end

   always_ff @(posedge clk) begin
      if (reset)
         ones_req <= 1'b0;
      else
         ones_req <= tx_clk_level && high_ticks > HIGH_MCLK; // [RQ15]
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   chk_low_powerdown : assert property (!tx_clk_level && low_ticks > LOW_MCLK |=> pd_req) // [RQ3]
      else $error("transmit clock held low did not power down");
   chk_high_ones : assert property ($rose(ones_req) |-> $past(tx_clk_level) && $past(high_ticks) > HIGH_MCLK) // [RQ15]
      else $error("all-ones entered without long high transmit clock");
endmodule : lprc_tx_clk_mon

// ==== testbench/lprc_far_end.sv ====
// Framer and line model: transmit clocks, transmit rails and recovered line rails
module lprc_far_end (
   input  wire logic       mclk,
   input  wire logic       run,
   input  wire logic [7:0] hold_low,
   input  wire logic [7:0] hold_high,
   output logic      [7:0] tx_clock_in,
   output logic      [7:0] tx_data_pos_in,
   output logic      [7:0] tx_violation_neg_in,
   output logic      [7:0] rx_line_pos,
   output logic      [7:0] rx_line_neg
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] pick;
   initial begin
      tx_data_pos_in = 8'h00;
      tx_violation_neg_in = 8'h00;
      rx_line_pos = 8'h00;
      rx_line_neg = 8'h00;
   end
   // *******************************************
   // Rails change away from the sampling edge; a mark is never on both rails
   // *******************************************
   always @(negedge mclk) begin
      pick = 8'($urandom);
      tx_data_pos_in <= pick;
      tx_violation_neg_in <= 8'($urandom) & ~pick;
      pick = 8'($urandom);
      rx_line_pos <= pick;
      rx_line_neg <= 8'($urandom) & ~pick;
   end
   // Framer clock follows the master clock unless a channel is held low or high
   assign tx_clock_in = ({8{mclk & run}} | hold_high) & ~hold_low;
endmodule : lprc_far_end

// ==== testbench/lprc_top_tb.sv ====
// Self-checking bench for the loopback, power-down and reset control block
module lprc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 0, reset = 1, mclk = 0, run = 1, host_mode = 1, wr_en = 0, rd_en = 0, ireset, dl_chk = 0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wr_data = 8'h00, pin = 8'h00, hold_low = 8'h00, los = 8'h00, hold_high = 8'h00;
   logic [7:0] rd_data, txc, tdp, tdn, rlp, rln, tlp, tln, toe, rdp, rdn, txpd, rxpd;
   int         miscompares = 0, samples_checked = 0, n, model [16];
   always #12.5 clk = ~clk;
   always #15 mclk = run ? ~mclk : 1'b0;
   lprc_far_end u_far (.mclk(mclk), .run(run), .hold_low(hold_low), .hold_high(hold_high), .tx_clock_in(txc),
      .tx_data_pos_in(tdp),
      .tx_violation_neg_in(tdn), .rx_line_pos(rlp), .rx_line_neg(rln));
   lprc_top u_dut (.clk(clk), .reset(reset), .mclk(mclk), .mclk_level(mclk), .host_mode(host_mode),
      .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .tx_clock_in(txc),
      .loop_select_pin(pin), .tx_data_pos_in(tdp), .tx_violation_neg_in(tdn), .rx_line_pos(rlp),
      .rx_line_neg(rln), .los_in(los), .tx_line_pos(tlp), .tx_line_neg(tln), .tx_line_oe(toe),
      .rx_data_pos_out(rdp), .rx_violation_neg_out(rdn), .tx_powered_down(txpd), .rx_powered_down(rxpd),
      .internal_reset(ireset));
   task automatic final_report();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report
   task automatic check_port(input logic [7:0] got, input logic [7:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check_port
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      if (a == 4'h1) model = '{default: 0};
      else if (a < 4'hA) model[a] = d;
   endtask : wr
   task automatic check_reg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      @(negedge clk);
      check_port(rd_data, 8'(model[a]), "register read");
   endtask : check_reg
   task automatic wait_idle(output int cyc);
      cyc = 0;
      while (ireset !== 1'b0) begin
         @(posedge clk);
         cyc++;
         if (cyc > 2000) begin
            miscompares++;
            final_report();
         end
      end
   endtask : wait_idle
   // Rails registered at the edge, sources move only at the falling edge; channel 0 dual, channel 2 remote
   always @(posedge mclk) begin
      #1;
      if (dl_chk) check_port(rdp, {rlp[7:1], tdp[0]}, "receive rails");
      if (dl_chk) check_port(rdn, {rln[7:1], tdn[0]}, "receive violation rail");
      if (dl_chk) check_port(tlp, {tdp[7:3], rlp[2], tdp[1], rlp[0]}, "line rails");
      if (dl_chk) check_port(tln, {tdn[7:3], rln[2], tdn[1], rln[0]}, "line violation rail");
   end
   // *******************************************
   // Scenarios
   // *******************************************
   initial begin
      model = '{default: 0};
      n = $urandom(26750);
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      wait_idle(n);
      check_port(8'(n >= lprc_pkg::POWER_ON_CYC), 8'h01, "power-on length");
      for (int i = 0; i < 16; i++) if (i < 10 || i == 15) check_reg(4'(i));
      for (int i = 0; i < 10; i++) if (i != 1) wr(4'(i), 8'($urandom));
      wr(4'hF, 8'hFF);
      for (int i = 0; i < 16; i++) if (i != 1 && (i < 10 || i == 15)) check_reg(4'(i));
      repeat (20) @(posedge clk);
      check_port(txpd, 8'(model[2]), "tx power-down");
      check_port(rxpd, 8'(model[3]), "rx power-down");
      wr(4'h1, 8'hA5); // Leaves auto ones off for the loops
      @(negedge clk);
      check_port({7'h00, ireset}, 8'h01, "soft reset start");
      wait_idle(n);
      check_port(8'(n >= lprc_pkg::SOFT_RESET_CYC - 2 && n <= lprc_pkg::SOFT_RESET_CYC + 3), 8'h01, "soft len");
      for (int i = 0; i < 10; i++) check_reg(4'(i));
      wr(4'h4, 8'h01);
      wr(4'h6, 8'h05);
      repeat (10) @(posedge mclk);
      dl_chk = 1;
      repeat (60) @(posedge mclk);
      dl_chk = 0;
      check_port(toe, 8'hFF, "driver enable");
      wr(4'h9, 8'h10);
      repeat (20) @(posedge clk);
      check_port(toe, 8'hEF, "high impedance");
      @(posedge clk);
      hold_low <= 8'h02;
      repeat (50) @(posedge mclk);
      check_port(txpd, 8'h00, "tx clock low early");
      repeat (50) @(posedge mclk);
      check_port(txpd, 8'h02, "tx clock low long");
      @(posedge clk);
      host_mode <= 1'b0;
      hold_high <= 8'h08;
      model[12] = 8'h08;
      model[14] = 2;
      repeat (40) @(posedge mclk);
      check_reg(4'hC);
      check_reg(4'hE);
      @(posedge clk);
      run <= 1'b0;
      repeat (40) @(posedge clk);
      check_port(rxpd, 8'hFF, "master clock low");
      final_report();
   end
endmodule : lprc_top_tb
